// ### depc_defs.svh
// Register selectors, field positions and reset values for the event counters
`ifndef DEPC_DEFS_SVH
`define DEPC_DEFS_SVH
`define DEPC_SEL_CONFIG_0 2'h0
`define DEPC_SEL_CONFIG_1 2'h1
`define DEPC_SEL_COUNT_0 2'h2
`define DEPC_SEL_COUNT_1 2'h3
`define DEPC_CFG_RESET 32'h0000_0000
`define DEPC_CNT_RESET 40'h00_0000_0000
`define DEPC_FLD_LOW_PRIV 16
`define DEPC_FLD_KERNEL 17
`define DEPC_FLD_EDGE 18
`define DEPC_FLD_PIN_INC 19
`define DEPC_FLD_IRQ 20
`define DEPC_FLD_GLOBAL_EN 22
`define DEPC_FLD_FLIP 23
`define DEPC_FLD_PERMIT 8
`endif

// ### depc_pkg.sv
// Types shared by the event counter files
package depc_pkg;
   typedef struct packed {
      logic [7:0] per_cycle_threshold;
      logic threshold_flip;
      logic global_enable;
      logic reserved_21;
      logic irq_enable;
      logic pin_on_increment;
      logic edge_detect;
      logic kernel_level_count;
      logic low_privilege_count;
      logic [7:0] event_qualifier;
      logic [7:0] event_code;
   } depc_config_s;
   typedef struct packed {
      logic valid;
      logic write;
      logic [1:0] select;
      logic [39:0] wdata;
   } depc_req_s;
endpackage

// ### depc_counter_lane.sv
// One 40-bit event counter lane with qualification and pin/interrupt pulses
`timescale 1ns/100ps
`default_nettype none
`include "depc_defs.svh"
module depc_counter_lane #(
   parameter int WIDTH = 40,
   parameter int EVW = 4
) (
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire depc_pkg::depc_config_s i_config,
   input wire logic i_active,
   input wire logic i_kernel,
   input wire logic [EVW-1:0] i_event_count,
   input wire logic i_load,
   input wire logic [31:0] i_load_value,
   output logic [WIDTH-1:0] o_count,
   output logic o_monitor_pin,
   output logic o_irq
);
   import depc_pkg::*;
   logic [WIDTH-1:0] next_count;
   logic next_pin;
   logic next_irq;
   logic cond_prev;
   logic next_cond_prev;
   logic priv_ok;
   logic cond;
   logic [EVW-1:0] add;
   logic [WIDTH:0] sum;
   always_comb begin
      // R5 R6 privilege window
      priv_ok = (i_kernel && i_config.kernel_level_count) ||
                (!i_kernel && i_config.low_privilege_count);
      add = '0;
      cond = 1'b0;
      // R12 R13 threshold compare, flip
      if (i_config.per_cycle_threshold != 8'h00) begin
         cond = ({{(8 > EVW ? 8 - EVW : 0){1'b0}}, i_event_count} >=
                 i_config.per_cycle_threshold) ^ i_config.threshold_flip;
         add = EVW'(cond);
      end else begin
         // R2 R14 add full per-cycle count
         cond = i_event_count != '0;
         add = i_event_count;
      end
      next_cond_prev = cond && priv_ok && i_active;
      // R7 edge detect rising only
      if (i_config.edge_detect) begin
         add = EVW'(next_cond_prev && !cond_prev);
      end
      if (!(priv_ok && i_active)) begin
         add = '0;
      end
      sum = {1'b0, o_count} + {{(WIDTH + 1 - EVW){1'b0}}, add};
      next_count = sum[WIDTH-1:0];
      // R15 sign extend bit 31
      if (i_load) begin
         next_count = {{(WIDTH - 32){i_load_value[31]}}, i_load_value};
      end
      // R8 R9 R21 one-cycle pin pulse
      next_pin = i_config.pin_on_increment ? (add != '0) : sum[WIDTH];
      // R10 R21 overflow interrupt
      next_irq = i_config.irq_enable && sum[WIDTH];
      if (i_load) begin
         next_pin = 1'b0;
         next_irq = 1'b0;
      end
   end
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_count <= `DEPC_CNT_RESET;
         o_monitor_pin <= 1'b0;
         o_irq <= 1'b0;
         cond_prev <= 1'b0;
      end else begin
         o_count <= next_count;
         o_monitor_pin <= next_pin;
         o_irq <= next_irq;
         cond_prev <= next_cond_prev;
      end
   end
endmodule
`default_nettype wire

// ### depc_dual_event_perf_counter.sv
// Dual event performance counter: register access and two counter lanes
// Functional notes
// R1 - Two independent 40-bit counters
// R2 - Duration mode counts clocks condition true
// R3 - Bits 7:0 select event unit
// R4 - Bits 15:8 qualify the event
// R5 - Bit 16 counts at levels 1-3
// R6 - Bit 17 counts at level 0
// R7 - Bit 18 counts rising edges only
// R8 - Bit 19 pin per increment else overflow
// R9 - Pin pulse lasts one clock
// R10 - Bit 20 raises overflow interrupt request
// R11 - Bit 22 of config 0 enables both
// R12 - Bit 23 flips threshold compare sense
// R13 - Nonzero threshold adds one when met
// R14 - Zero threshold adds per-cycle event count
// R15 - Counter write sign-extends bit 31
// R16 - User read gated by permit bit
// R17 - Privileged access only at level 0
// R18 - Counting starts right after enable write
// R19 - Clearing configs stops counting
// R20 - User read samples without serializing
// R21 - Overflow is wrap past all ones
`timescale 1ns/100ps
`default_nettype none
`include "depc_defs.svh"
module depc_dual_event_perf_counter #(
   parameter int WIDTH = 40,
   parameter int EVW = 4
) (
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic [1:0] i_privilege_level,
   input wire logic i_user_read_permit,
   input wire depc_pkg::depc_req_s i_req,
   input wire logic i_user_counter_read,
   input wire logic i_user_read_select,
   input wire logic [255:0] i_event_lines_0,
   input wire logic [255:0] i_event_lines_1,
   output logic [63:0] o_rdata,
   output logic o_rdata_valid,
   output logic o_fault,
   output logic [7:0] o_event_qualifier_0,
   output logic [7:0] o_event_qualifier_1,
   output logic [1:0] o_monitor_pin,
   output logic o_interrupt_request
);
   import depc_pkg::*;
   depc_config_s event_config_0;
   depc_config_s event_config_1;
   depc_config_s next_config_0;
   depc_config_s next_config_1;
   logic [63:0] next_rdata;
   logic next_valid;
   logic next_fault;
   logic [WIDTH-1:0] count_0;
   logic [WIDTH-1:0] count_1;
   logic [1:0] lane_irq;
   logic kernel;
   logic priv_ok;
   logic [1:0] load;
   logic active_0;
   logic active_1;
   logic [EVW-1:0] ev_0;
   logic [EVW-1:0] ev_1;

   // Event lines carry one bit per unit; code picks one, a hit counts as one
   function automatic logic [EVW-1:0] pick(input logic [255:0] lines, input logic [7:0] code);
      pick = EVW'(lines[code]);
   endfunction

   function automatic logic [63:0] count_word(input logic [WIDTH-1:0] c);
      count_word = {{(64 - WIDTH){1'b0}}, c};
   endfunction

   assign kernel = i_privilege_level == 2'b00;
   // R17 privileged access level 0
   assign priv_ok = i_req.valid && kernel;
   assign load[0] = priv_ok && i_req.write && i_req.select == `DEPC_SEL_COUNT_0;
   assign load[1] = priv_ok && i_req.write && i_req.select == `DEPC_SEL_COUNT_1;
   // R3 event select decode
   assign ev_0 = pick(i_event_lines_0, event_config_0.event_code);
   assign ev_1 = pick(i_event_lines_1, event_config_1.event_code);
   // R4 qualifier drives event units
   assign o_event_qualifier_0 = event_config_0.event_qualifier;
   assign o_event_qualifier_1 = event_config_1.event_qualifier;
   // R11 R18 R19 global enable gating
   assign active_0 = event_config_0.global_enable && (event_config_0 != '0);
   assign active_1 = event_config_0.global_enable && (event_config_1 != '0);

   always_comb begin
      next_config_0 = event_config_0;
      next_config_1 = event_config_1;
      if (priv_ok && i_req.write && i_req.select == `DEPC_SEL_CONFIG_0) begin
         next_config_0 = depc_config_s'(i_req.wdata[31:0]);
      end
      if (priv_ok && i_req.write && i_req.select == `DEPC_SEL_CONFIG_1) begin
         next_config_1 = depc_config_s'(i_req.wdata[31:0]);
         // Enable flag lives only in the first config register
         next_config_1.global_enable = 1'b0;
      end
      next_config_0.reserved_21 = 1'b0;
      next_config_1.reserved_21 = 1'b0;
   end

   always_comb begin
      next_rdata = o_rdata;
      next_valid = 1'b0;
      next_fault = 1'b0;
      if (i_req.valid && !kernel) begin
         next_fault = 1'b1;
      end else if (priv_ok && !i_req.write) begin
         next_valid = 1'b1;
         unique case (i_req.select)
            `DEPC_SEL_CONFIG_0: next_rdata = {32'h0000_0000, event_config_0};
            `DEPC_SEL_CONFIG_1: next_rdata = {32'h0000_0000, event_config_1};
            `DEPC_SEL_COUNT_0: next_rdata = count_word(count_0);
            default: next_rdata = count_word(count_1);
         endcase
      // User read yields to a register request in the same cycle
      end else if (i_user_counter_read && !i_req.valid) begin
         // R16 permit bit gates user read
         if (i_user_read_permit && !kernel) begin
            next_fault = 1'b1;
         end else begin
            next_valid = 1'b1;
            // R20 samples live count, no ordering
            next_rdata = count_word(i_user_read_select ? count_1 : count_0);
         end
      end
   end

   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         event_config_0 <= `DEPC_CFG_RESET;
         event_config_1 <= `DEPC_CFG_RESET;
         o_rdata <= 64'h0000_0000_0000_0000;
         o_rdata_valid <= 1'b0;
         o_fault <= 1'b0;
      end else begin
         event_config_0 <= next_config_0;
         event_config_1 <= next_config_1;
         o_rdata <= next_rdata;
         o_rdata_valid <= next_valid;
         o_fault <= next_fault;
      end
   end

   // R1 two independent lanes
   depc_counter_lane #(.WIDTH(WIDTH), .EVW(EVW)) u_lane_0 (
      .i_clock(i_clock),
      .i_reset_n(i_reset_n),
      .i_config(event_config_0),
      .i_active(active_0),
      .i_kernel(kernel),
      .i_event_count(ev_0),
      .i_load(load[0]),
      .i_load_value(i_req.wdata[31:0]),
      .o_count(count_0),
      .o_monitor_pin(o_monitor_pin[0]),
      .o_irq(lane_irq[0])
   );
   depc_counter_lane #(.WIDTH(WIDTH), .EVW(EVW)) u_lane_1 (
      .i_clock(i_clock),
      .i_reset_n(i_reset_n),
      .i_config(event_config_1),
      .i_active(active_1),
      .i_kernel(kernel),
      .i_event_count(ev_1),
      .i_load(load[1]),
      .i_load_value(i_req.wdata[31:0]),
      .o_count(count_1),
      .o_monitor_pin(o_monitor_pin[1]),
      .o_irq(lane_irq[1])
   );
   // R10 one request line to the local interrupt controller
   assign o_interrupt_request = |lane_irq;
endmodule
`default_nettype wire

// ### depc_dual_event_perf_counter_properties.sv
// Port checks for the dual event counter
`timescale 1ns/100ps
`default_nettype none
module depc_checker (
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic [1:0] i_privilege_level,
   input wire logic i_user_read_permit,
   input wire depc_pkg::depc_req_s i_req,
   input wire logic i_user_counter_read,
   input wire logic [63:0] o_rdata,
   input wire logic o_rdata_valid,
   input wire logic o_fault
);
   import depc_pkg::*;
   logic k, r, u, d, q;
   assign k = i_privilege_level == 2'h0;
   assign r = i_req.valid;
   assign u = i_user_counter_read && !r;
   assign d = i_user_read_permit && !k;
   assign q = o_rdata_valid || o_fault;
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_reset_n);
   AST_PRIV_FAULT: assert property (r && !k |=> o_fault && !o_rdata_valid) else $error("no fault");
   AST_PRIV_READ: assert property (r && !i_req.write && k |=> o_rdata_valid) else $error("no data");
   AST_WRITE_QUIET: assert property (r && i_req.write && k |=> !q) else $error("write answered");
   AST_USER_DENY: assert property (u && d |=> o_fault) else $error("user read let through");
   AST_USER_OK: assert property (u && !d |=> o_rdata_valid) else $error("user read refused");
   AST_IDLE_QUIET: assert property (!r && !i_user_counter_read |=> !q) else $error("stray answer");
   AST_RDATA_HOLD: assert property (!o_rdata_valid |-> $stable(o_rdata)) else $error("data moved");
   AST_UPPER_ZERO: assert property (o_rdata_valid |-> o_rdata[63:40] == 24'h0) else $error("upper set");
endmodule
bind depc_dual_event_perf_counter depc_checker u_checker (.i_clock(i_clock),
   .i_reset_n(i_reset_n), .i_privilege_level(i_privilege_level),
   .i_user_read_permit(i_user_read_permit), .i_req(i_req),
   .i_user_counter_read(i_user_counter_read), .o_rdata(o_rdata),
   .o_rdata_valid(o_rdata_valid), .o_fault(o_fault));
`default_nettype wire

// ### depc_dual_event_perf_counter_tb.sv
// Random and corner tests of the dual event counter
`timescale 1ns/100ps
`default_nettype none
module depc_dual_event_perf_counter_tb;
   import depc_pkg::*;
   logic i_clock, i_reset_n, i_user_read_permit, i_user_counter_read, i_user_read_select;
   logic o_rdata_valid, o_fault, o_interrupt_request, f, v;
   logic [1:0] i_privilege_level, o_monitor_pin;
   logic [255:0] i_event_lines_0, i_event_lines_1, ln;
   logic [63:0] o_rdata, rd;
   logic [7:0] o_event_qualifier_0, o_event_qualifier_1;
   logic [31:0] c;
   depc_req_s i_req;
   int n_mismatch = 0, checked = 0, cyc = 0, n_pin = 0, n_irq = 0;
   depc_dual_event_perf_counter uut (.i_clock(i_clock), .i_reset_n(i_reset_n),
      .i_privilege_level(i_privilege_level), .i_user_read_permit(i_user_read_permit),
      .i_req(i_req), .i_user_counter_read(i_user_counter_read),
      .i_user_read_select(i_user_read_select), .i_event_lines_0(i_event_lines_0),
      .i_event_lines_1(i_event_lines_1), .o_rdata(o_rdata), .o_rdata_valid(o_rdata_valid),
      .o_fault(o_fault), .o_event_qualifier_0(o_event_qualifier_0),
      .o_event_qualifier_1(o_event_qualifier_1), .o_monitor_pin(o_monitor_pin),
      .o_interrupt_request(o_interrupt_request));
   initial begin
      i_clock = 0;
      forever #2 i_clock = ~i_clock;
   end
   // Pulses counted on the quiet edge
   always @(negedge i_clock) begin
      cyc++;
      n_pin += o_monitor_pin[0] + o_monitor_pin[1];
      n_irq += o_interrupt_request;
      if (cyc == 3000) begin
         n_mismatch++;
         summarize();
      end
   end
   task automatic chk(input string n, input logic [63:0] s, e);
      checked++;
      if (s !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic summarize();
      $display("Checks %0d, mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic acc(input logic u, w, input logic [1:0] s, input logic [39:0] d,
         input logic [1:0] lv);
      i_privilege_level = lv;
      i_user_counter_read = u;
      i_user_read_select = s[0];
      // Valid stays up between back-to-back calls; the caller drops it when idle
      i_req = '{~u, w, s, d};
      @(negedge i_clock);
      // Answer stands only in the cycle after the taking edge
      f = o_fault;
      v = o_rdata_valid;
      rd = o_rdata;
   endtask
   function automatic logic nxt(input logic [31:0] c, input logic [1:0] lv, input logic e,
         inout logic pv);
      logic q;
      q = c[22] && (lv == 2'h0 ? c[17] : c[16]);
      q = q && (c[31:24] != 8'h00 ? (8'(e) >= c[31:24]) ^ c[23] : e);
      nxt = c[18] ? q && !pv : q;
      pv = q;
   endfunction
   task automatic run(input logic l, input logic [31:0] c, st, pat);
      logic [39:0] cnt;
      logic pv, w;
      logic [1:0] lv;
      int ep, ei;
      cnt = {{8{st[31]}}, st};
      pv = 1'b0;
      ep = 0;
      ei = 0;
      i_event_lines_0 = '0;
      i_event_lines_1 = '0;
      if (l) acc(1'b0, 1'b1, 2'h0, 40'h00_0040_0000, 2'h0);
      acc(1'b0, 1'b1, {1'b1, l}, {8'h00, st}, 2'h0);
      // Refused write must leave the counter alone
      acc(1'b0, 1'b1, {1'b1, l}, 40'h00_0000_0001, 2'h3);
      chk("refused", f, 1'b1);
      acc(1'b0, 1'b1, {1'b0, l}, {8'h00, c}, 2'h0);
      n_pin = 0;
      n_irq = 0;
      for (int i = 0; i < 20; i++) begin
         ln = {8{$urandom}};
         ln[c[7:0]] = pat[i];
         i_event_lines_0 = ln;
         i_event_lines_1 = ln;
         // Last step's level comes from the closing write, so it is 0
         lv = i == 19 ? 2'h0 : 2'($urandom);
         if (i < 19) i_privilege_level = lv;
         if (i == 0) begin
            i_req.valid = 1'b0;
            i_user_counter_read = 1'b0;
         end
         if (nxt(c | {9'h000, l, 22'h00_0000}, lv, pat[i], pv)) begin
            {w, cnt} = {1'b0, cnt} + 41'h001;
            ep += c[19] | w;
            ei += c[20] & w;
         end
         if (i < 19) @(negedge i_clock);
      end
      acc(1'b0, 1'b1, {1'b0, l}, 40'h00_0000_0000, 2'h0);
      for (int p = 0; p < 8; p++) begin
         i_user_read_permit = p[2];
         acc(1'b1, 1'b0, {1'b0, l}, 40'h00_0000_0000, 2'(p));
         chk("user fault", f, p > 4);
         if (p < 5) chk("count", rd, {24'h00_0000, cnt});
      end
      chk("pins", n_pin, ep);
      chk("requests", n_irq, ei);
      if (l) acc(1'b0, 1'b1, 2'h0, 40'h00_0000_0000, 2'h0);
      $display("Counting test on counter %0d done", l);
   endtask
   initial begin
      {i_reset_n, i_user_read_permit, i_user_counter_read, i_user_read_select} = 4'h0;
      i_privilege_level = 2'h0;
      i_req = '0;
      i_event_lines_0 = '0;
      i_event_lines_1 = '0;
      void'($urandom(61));
      repeat (10) @(negedge i_clock);
      i_reset_n = 1'b1;
      for (int s = 0; s < 4; s++) begin
         c = $urandom & 32'hFFBF_FFFF;
         acc(1'b0, 1'b0, 2'(s), 40'h00_0000_0000, 2'h0);
         chk("reset", rd, 64'h0000_0000_0000_0000);
         chk("valid", v, 1'b1);
         acc(1'b0, 1'b1, 2'(s), {8'h00, c}, 2'h0);
         acc(1'b0, 1'b0, 2'(s), 40'h00_0000_0000, 2'h0);
         chk("reg", rd, s > 1 ? {24'h00_0000, {8{c[31]}}, c} : c & 32'hFF9F_FFFF);
         if (s < 2) chk("qual", s ? o_event_qualifier_1 : o_event_qualifier_0, c[15:8]);
         if (s < 2) acc(1'b0, 1'b1, 2'(s), 40'h00_0000_0000, 2'h0);
      end
      $display("Register test done");
      // Steady condition counts once
      run(1'b1, 32'h000F_0009, 32'h0000_0000, 32'hFFFF_FFFF);
      // Wrap gives one pin and one request
      run(1'b0, 32'h0073_0003, 32'hFFFF_FFFE, 32'hFFFF_FFFF);
      repeat (10) begin
         c = $urandom & 32'h03DF_FFFF | 32'h0040_0000;
         run(1'($urandom), c, $urandom % 2 ? $urandom | 32'hFFFF_FFF0 : $urandom, $urandom);
      end
      summarize();
   end
endmodule
`default_nettype wire
